// ===== inc/button_pkg.sv
/*
 * Constants and types shared by the front panel user button logic.
 * Assumes a 40 MHz mclk and that all consumers import this package.
 */
package button_pkg;

    // ********************************************************************
    // Channel count and modes
    // ********************************************************************
    localparam int NUM_BUTTONS = 12;
    localparam logic MODE_MOMENTARY = 1'b0;
    localparam logic MODE_LATCHING  = 1'b1;
    localparam logic [11:0] MODE_RESET = 12'h000;

    // ********************************************************************
    // Debounce timing
    // ********************************************************************
    localparam int CLK_HZ      = 40000000;
    // Short filter keeps runs quick; raise it for heavily bouncing contacts
    localparam int DEBOUNCE_US = 50;
    localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000000) * DEBOUNCE_US;
    localparam int DB_CNT_W = 18;

    // ********************************************************************
    // Indicator colour and source
    // ********************************************************************
    localparam logic [1:0] COLOUR_RED    = 2'h0;
    localparam logic [1:0] COLOUR_ORANGE = 2'h1;
    localparam logic [1:0] COLOUR_GREEN  = 2'h2;
    localparam logic [1:0] COLOUR_RESET  = 2'h2;
    localparam logic SRC_STATUS = 1'b0;
    localparam logic SRC_OTHER  = 1'b1;

    // ********************************************************************
    // Register map of the plain register port
    // ********************************************************************
    localparam logic [3:0] ADDR_MODE    = 4'h0;
    localparam logic [3:0] ADDR_COLOUR  = 4'h1;
    localparam logic [3:0] ADDR_LEDSRC  = 4'h2;
    localparam logic [3:0] ADDR_STATUS  = 4'h3;
    localparam logic [3:0] ADDR_RAWBTN  = 4'h4;
    localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;

    typedef struct packed {
        logic        red;
        logic        green;
    } led_drive_type;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_type;

endpackage : button_pkg

// ===== rtl/button_debounce.sv
/*
 * One button contact: two-stage synchroniser, then a stable-time filter.
 * Assumes an asynchronous, bouncing contact, high while pressed.
 */
`timescale 1ns/1ps
module button_debounce (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // Contact
    input  wire logic contact,
    // Filtered level
    output logic      pressed
);
    import button_pkg::*;

    logic                sync1_ff;
    logic                sync2_ff;
    logic                pressed_ff;
    logic [DB_CNT_W-1:0] cnt_ff;
    logic [DB_CNT_W-1:0] nxt_cnt;
    wire                 differs = sync2_ff != pressed_ff;
    wire                 done    = cnt_ff == DB_CNT_W'(DEBOUNCE_CYCLES - 1);

    // Restart the count whenever the input agrees with the filtered level
    assign nxt_cnt = differs ? cnt_ff + 1'b1 : '0;
    assign pressed = pressed_ff;

    always_ff @(posedge mclk) begin
        if (reset) begin
            sync1_ff   <= 1'b0;
            sync2_ff   <= 1'b0;
            pressed_ff <= 1'b0;
            cnt_ff     <= '0;
        end else begin
            sync1_ff <= contact;
            sync2_ff <= sync1_ff;
            cnt_ff   <= (differs && done) ? '0 : nxt_cnt;
            if (differs && done) begin
                pressed_ff <= sync2_ff;
            end
        end
    end

endmodule : button_debounce

// ===== rtl/button_led.sv
/*
 * Indicator driver: selects the lit source and maps colour to two dies.
 * Assumes a bicolour LED where red plus green shows orange.
 */
`timescale 1ns/1ps
module button_led (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   reset,
    // Settings
    input  wire logic [1:0]             colour,
    input  wire logic                   src_sel,
    // Sources
    input  wire logic                   status,
    input  wire logic                   other,
    // Die drive
    output button_pkg::led_drive_type   led
);
    import button_pkg::*;

    led_drive_type led_ff;
    wire           lit = (src_sel == SRC_OTHER) ? other : status;
    wire           want_red   = colour == COLOUR_RED ||
                                colour == COLOUR_ORANGE;
    wire           want_green = colour == COLOUR_GREEN ||
                                colour == COLOUR_ORANGE;

    assign led = led_ff;

    always_ff @(posedge mclk) begin
        if (reset) begin
            led_ff <= '0;
        end else begin
            led_ff.red   <= lit & want_red;
            led_ff.green <= lit & want_green;
        end
    end

endmodule : button_led

// ===== rtl/front_panel_user_buttons.sv
/*
 * Twelve front panel user buttons with mode, status pairs and LEDs.
 * Assumes raw contacts from the panel and a same-clock register port.
 */
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module front_panel_user_buttons (
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    reset,
    // Panel contacts, high while pressed
    input  wire logic [11:0]             button_contact,
    // Other binary signals that may light an LED
    input  wire logic [11:0]             led_other,
    // Register port
    input  wire logic [3:0]              reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [31:0]                  reg_rdata,
    // Status outputs
    output logic [11:0]                  status_on,
    output logic [11:0]                  status_off,
    // Indicators
    output button_pkg::led_drive_type    led [12]
);
    import button_pkg::*;

    // ********************************************************************
    // Settings registers
    // ********************************************************************
    logic [11:0] button_mode_select_ff;
    logic [23:0] colour_ff;
    logic [11:0] led_src_ff;
    logic [31:0] rdata_ff;
    reg_req_type req;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    wire wr_mode   = req.wr && req.addr == ADDR_MODE;
    wire wr_colour = req.wr && req.addr == ADDR_COLOUR;
    wire wr_ledsrc = req.wr && req.addr == ADDR_LEDSRC;

    always_ff @(posedge mclk) begin
        if (reset) begin
            button_mode_select_ff <= MODE_RESET;
            colour_ff             <= {NUM_BUTTONS{COLOUR_RESET}};
            led_src_ff            <= '0;
        end else begin
            if (wr_mode) begin
                button_mode_select_ff <= req.wdata[11:0];
            end
            if (wr_colour) begin
                colour_ff <= req.wdata[23:0];
            end
            if (wr_ledsrc) begin
                led_src_ff <= req.wdata[11:0];
            end
        end
    end

    // ********************************************************************
    // Button channels
    // ********************************************************************
    logic [11:0] pressed;
    logic [11:0] pressed_d_ff;
    logic [11:0] latch_ff;
    logic [11:0] status_ff;
    logic [11:0] nxt_status;
    wire  [11:0] press_edge = pressed & ~pressed_d_ff;

    function automatic logic chan_next(input logic mode,
                                       input logic held,
                                       input logic latched);
        begin
            chan_next = (mode == MODE_LATCHING) ? latched : held;
        end
    endfunction : chan_next

    genvar g;
    generate
        for (g = 0; g < NUM_BUTTONS; g++) begin : g_chan
            button_debounce u_db (
                .mclk    (mclk),
                .reset   (reset),
                .contact (button_contact[g]),
                .pressed (pressed[g])
            );

            assign nxt_status[g] = chan_next(button_mode_select_ff[g],
                                             pressed[g],
                                             latch_ff[g] ^ press_edge[g]);

            button_led u_led (
                .mclk    (mclk),
                .reset   (reset),
                .colour  (colour_ff[2*g +: 2]),
                .src_sel (led_src_ff[g]),
                .status  (status_ff[g]),
                .other   (led_other[g]),
                .led     (led[g])
            );
        end
    endgenerate

    // Latch state only ever moves on a panel press; the register port has
    // no write path into it, though a mode write can still move the status.
    always_ff @(posedge mclk) begin
        if (reset) begin
            pressed_d_ff <= '0;
            latch_ff     <= '0;
            status_ff    <= '0;
        end else begin
            pressed_d_ff <= pressed;
            latch_ff     <= latch_ff ^ press_edge;
            status_ff    <= nxt_status;
        end
    end

    assign status_on  = status_ff;
    assign status_off = ~status_ff;

    // ********************************************************************
    // Read back
    // ********************************************************************
    logic [31:0] rd_mux;

    always_comb begin
        case (req.addr)
            ADDR_MODE:   rd_mux = {20'h00000, button_mode_select_ff};
            ADDR_COLOUR: rd_mux = {8'h00, colour_ff};
            ADDR_LEDSRC: rd_mux = {20'h00000, led_src_ff};
            ADDR_STATUS: rd_mux = {20'h00000, status_ff};
            ADDR_RAWBTN: rd_mux = {20'h00000, pressed};
            default:     rd_mux = DATA_ZERO;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_ff <= DATA_ZERO;
        end else begin
            rdata_ff <= req.rd ? rd_mux : DATA_ZERO;
        end
    end

    assign reg_rdata = rdata_ff;

endmodule : front_panel_user_buttons

// ===== verification/panel_checker.sv
/* Assertions on the user button block ports.
   Assumes binding to the top module, one clock, sync reset. */
`timescale 1ns/1ps
module panel_checker
    import button_pkg::*;
(
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic [11:0] button_contact,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_rdata,
    input wire logic [11:0] status_on,
    input wire logic [11:0] status_off,
    input wire led_drive_type led [12]
);
    // ****************************************************************
    // Helper counters
    // ****************************************************************
    logic [11:0] last_ff;
    logic [17:0] chg_ff;
    logic [1:0]  age_ff;
    always_ff @(posedge mclk) begin
        last_ff <= button_contact;
        if (reset || button_contact != last_ff) chg_ff <= 18'h0;
        else if (chg_ff != 18'h3ffff) chg_ff <= chg_ff + 18'h1;
        if (reset || reg_wr) age_ff <= 2'h0;
        else if (age_ff != 2'h3) age_ff <= age_ff + 2'h1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // ****************************************************************
    // Properties
    // ****************************************************************
    chk_pair_compl: assert property (status_off == ~status_on)
        else $error("status pair not complementary");
    chk_reset_off: assert property ($fell(reset) |-> status_on == 12'h0)
        else $error("status not off after reset");
    chk_led_dark: assert property ($fell(reset) |-> led[0] == 2'h0)
        else $error("indicator lit after reset");
    chk_wr_ignored: assert property (reg_wr && reg_addr == ADDR_STATUS
        |=> status_on == $past(status_on))
        else $error("status moved by register write");
    chk_debounce_win: assert property ($changed(status_on) && age_ff == 2'h3
        |-> chg_ff > 18'h007c6 && chg_ff < 18'h007da)
        else $error("status changed outside debounce time");
    chk_rise_press: assert property ($rose(status_on[0]) && age_ff == 2'h3
        |-> button_contact[0])
        else $error("status rose without press");
    chk_rise_eleven: assert property ($rose(status_on[11]) && age_ff == 2'h3
        |-> button_contact[11])
        else $error("channel eleven rose without press");
    chk_rd_status: assert property (reg_rd && reg_addr == ADDR_STATUS
        |=> reg_rdata[11:0] == $past(status_on))
        else $error("status read mismatch");
    cover property ($rose(status_on[0]));
    cover property ($fell(status_on[0]));
    cover property (reg_rd ##1 reg_rd);
endmodule : panel_checker

// ===== verification/button_panel.sv
/* Model of the operator's panel: bouncing contacts.
   Assumes the bench commands the wanted level on push. */
`timescale 1ns/1ps
module button_panel (
    // Clock
    input  wire logic        mclk,
    // Commanded level
    input  wire logic [11:0] push,
    // Contacts
    output logic      [11:0] contact
);
    logic [11:0] last;
    logic [3:0]  bnc;
    initial begin
        last = 12'h0;
        bnc = 4'h0;
        contact = 12'h0;
    end
    // Real contacts chatter a few cycles before they settle
    always @(posedge mclk) begin
        if (push !== last) begin
            bnc <= 4'h8;
            last <= push;
        end else if (bnc != 4'h0) bnc <= bnc - 4'h1;
        contact <= bnc[0] ? ~push : push;
    end
endmodule : button_panel

// ===== verification/tb.sv
/* Self-checking bench for the user buttons.
   Assumes the package debounce time of about 2000 cycles. */
`timescale 1ns/1ps
module tb;
    import button_pkg::*;
    logic          mclk, reset, reg_wr, reg_rd;
    logic [11:0]   push, led_other, contact, status_on, status_off;
    logic [3:0]    reg_addr;
    logic [31:0]   reg_wdata, reg_rdata;
    led_drive_type led [12];
    int            n_fail, cmp_count, cyc;
    button_panel panel (.mclk, .push, .contact);
    front_panel_user_buttons uut (.mclk, .reset, .button_contact(contact),
        .led_other, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .status_on, .status_off, .led);
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %h not %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'h1; reg_addr <= a; reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_rd <= 1'h1; reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1 check(reg_rdata, exp);
    endtask : rd
    task automatic wait_st(input logic [11:0] exp);
        int n = 0;
        while (status_on !== exp && n < 3000) begin
            @(posedge mclk);
            n++;
        end
        check({20'h0, status_on}, {20'h0, exp});
    endtask : wait_st
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        check({20'h0, status_off}, 32'hfff);
        rd(ADDR_MODE, 32'h0);
        rd(ADDR_COLOUR, 32'haaaaaa);
        rd(4'hf, 32'h0);
        wr(ADDR_STATUS, 32'hfff);
        rd(ADDR_STATUS, 32'h0);
    endtask : t_reset
    task automatic t_momentary();
        @(posedge mclk) push <= 12'h001;
        wait_st(12'h001);
        repeat (2) @(posedge mclk);
        check({30'h0, led[0]}, 32'h1);
        @(posedge mclk) push <= 12'h0;
        wait_st(12'h0);
    endtask : t_momentary
    task automatic t_latching();
        logic [1:0] want [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
        wr(ADDR_MODE, 32'h801);
        wait_st(12'h001);
        @(posedge mclk) push <= 12'h800;
        wait_st(12'h801);
        @(posedge mclk) push <= 12'h0;
        repeat (3000) @(posedge mclk);
        check({20'h0, status_on}, 32'h801);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_COLOUR, i);
            @(posedge mclk);
            #1 check({30'h0, led[0]}, {30'h0, want[i]});
        end
        wr(ADDR_COLOUR, 32'h2);
        wr(ADDR_LEDSRC, 32'h1);
        @(posedge mclk);
        #1 check({30'h0, led[0]}, 32'h0);
        @(posedge mclk) led_other <= 12'h001;
        repeat (3) @(posedge mclk);
        check({30'h0, led[0]}, 32'h1);
        @(posedge mclk) push <= 12'h001;
        wait_st(12'h800);
        @(posedge mclk) push <= 12'h0;
        repeat (3000) @(posedge mclk);
        check({20'h0, status_on}, 32'h800);
    endtask : t_latching
    // ****************************************************************
    // Clock, timeout and main sequence
    // ****************************************************************
    initial begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        {reset, reg_wr, reg_rd} = 3'h4;
        {push, led_other, reg_addr, reg_wdata} = '0;
        repeat (4) @(posedge mclk);
        reset <= 1'h0;
        t_reset();
        t_momentary();
        t_latching();
        conclude();
    end
endmodule : tb
bind front_panel_user_buttons panel_checker chk (.mclk, .reset,
    .button_contact, .reg_wr, .reg_rd, .reg_addr, .reg_rdata,
    .status_on, .status_off, .led);
